// >>> i2sc_codec_model.sv
`timescale 1ns/100ps
// External audio master for slave mode: it makes the bit and frame clocks and sends serial data.
module i2sc_codec_model (
    input wire logic clk_sys,
    output logic sck,
    output logic frame_select_clock,
    output logic serial_data_in
);
    logic active;

    // The clocks idle low, and the data line toggles outside frames, so stale bits are never mistaken for data.
    initial begin
        active = 1'b0;
        sck = 1'b0;
        frame_select_clock = 1'b0;
        serial_data_in = 1'b0;
    end

    // The line is only wiggled while no frame is being sent, so the two drivers never meet in one step.
    always @(posedge clk_sys) begin
        if (!active) begin
            serial_data_in <= ~serial_data_in;
        end
    end

    // Sends n words MSB first; the frame clock flips on a bit clock fall, and a final flip closes the last word.
    task automatic send(input int n, input logic [15:0] w);
        @(posedge clk_sys);
        active <= 1'b1;
        for (int j = 0; j < n; j++) begin
            for (int i = 15; i >= 0; i--) begin
                @(posedge clk_sys);
                sck <= 1'b0;
                serial_data_in <= w[i];
                if (i == 15) begin
                    frame_select_clock <= ~frame_select_clock;
                end
                repeat (2) @(posedge clk_sys);
                sck <= 1'b1;
                @(posedge clk_sys);
            end
        end
        @(posedge clk_sys);
        sck <= 1'b0;
        frame_select_clock <= ~frame_select_clock;
        @(posedge clk_sys);
        active <= 1'b0;
    endtask
endmodule

// >>> i2sc_core.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
module i2sc_core
    import i2sc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire i2sc_apb_req_t apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic mckOut,
    output logic mckOe,
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOe,
    input wire logic lrckIn,
    output logic lrckOut,
    output logic lrckOe,
    input wire logic sdinIn,
    output logic sdoutOut,
    output logic sdoutOe,
    output logic rxWordValid,
    output logic [31:0] rxWordAddr,
    output logic [WORD_BITS-1:0] rxWordData,
    input wire logic [WORD_BITS-1:0] txWordData,
    output logic txWordTake
);
    i2sc_state_t s_reg;
    i2sc_state_t s_next;
    logic wrEn;
    logic rdEn;
    logic hit;
    logic [31:0] rdVal;
    logic [9:0] lrEdges;
    logic [4:0] sckHalf;
    logic [2:0] evSet;
    logic [2:0] evClr;
    logic mckEdge;
    logic [32:0] accSum;
    logic [33:0] accLook;
    logic [31:0] accNext;
    logic sckNow;
    logic lrckNow;
    logic sckRise;
    logic sckFall;
    logic lrEdge;
    logic active;

    // Zero-wait slave: every access completes in its first access cycle.
    assign pready = 1'b1;
    assign wrEn = apbReq.psel & apbReq.penable & apbReq.pwrite;
    assign rdEn = apbReq.psel & apbReq.penable & ~apbReq.pwrite;
    assign active = (s_reg.run == I2SC_RUN) & s_reg.enable;

    // Read mux; an unmapped offset reads zero and flags an error.
    always_comb begin
        hit = 1'b1;
        rdVal = 32'h00000000;
        case (apbReq.paddr)
            OFS_START, OFS_STOP: rdVal = 32'h00000000;
            OFS_STATUS: rdVal = {29'h00000000, s_reg.status};
            OFS_MASK: rdVal = {29'h00000000, s_reg.mask};
            OFS_ENABLE: rdVal = {31'h00000000, s_reg.enable};
            OFS_MODE: rdVal = {31'h00000000, s_reg.mode};
            OFS_RECEIVE_ENABLE_BIT: rdVal = {31'h00000000, s_reg.receive_enable_bit};
            OFS_TRANSMIT_ENABLE_BIT: rdVal = {31'h00000000, s_reg.transmit_enable_bit};
            OFS_MASTER_CLOCK_GEN_ON: rdVal = {31'h00000000, s_reg.master_clock_gen_on};
            OFS_MASTER_CLOCK_FRACTION: rdVal = s_reg.master_clock_fraction;
            OFS_RATIO: rdVal = {28'h0000000, s_reg.ratio};
            OFS_SAMPLE_BITS: rdVal = {30'h00000000, s_reg.sampleBits};
            OFS_RXPTR: rdVal = s_reg.rxPtr;
            OFS_MAXCNT: rdVal = {18'h00000, s_reg.maxCnt};
            default: hit = 1'b0;
        endcase
    end
    assign prdata = rdEn ? rdVal : 32'h00000000;
    assign pslverr = apbReq.psel & apbReq.penable & ~hit;

    // Frame clock half period in master clock edges; codes above 8 act as 512.
    always_comb begin
        case (s_reg.ratio)
            4'h0: lrEdges = 10'h020;
            4'h1: lrEdges = 10'h030;
            4'h2: lrEdges = 10'h040;
            4'h3: lrEdges = 10'h060;
            4'h4: lrEdges = 10'h080;
            4'h5: lrEdges = 10'h0C0;
            4'h6: lrEdges = 10'h100;
            4'h7: lrEdges = 10'h180;
            default: lrEdges = 10'h200;
        endcase
        // Sixteen bit clocks per half frame; the 48x ratio truncates its bit clock.
        sckHalf = (lrEdges[9:5] == 5'h00) ? 5'h01 : lrEdges[9:5];
    end

    // Master clock divider: the code is added each cycle and the period closes when the
    // next addition would pass 2^32, so every listed code gives a whole divisor of the source.
    // clk_sys stands in for the source, so code 0x80000000 toggles every cycle.
    // Odd divisors cannot be symmetric; the high phase is the shorter one.
    assign accSum = {1'b0, s_reg.acc} + {1'b0, s_reg.master_clock_fraction};
    assign accLook = {1'b0, accSum} + {2'b00, s_reg.master_clock_fraction};
    assign accNext = (accLook > 34'h100000000) ? 32'h00000000 : accSum[31:0];
    assign mckEdge = active & (accNext[31] != s_reg.acc[31]);

    // Bit and frame clocks come from inside in master mode, from pins in slave.
    assign sckNow = s_reg.mode ? sckIn : s_reg.sck;
    assign lrckNow = s_reg.mode ? lrckIn : s_reg.frame_select_clock;
    assign sckRise = sckNow & ~s_reg.sckPrev;
    assign sckFall = ~sckNow & s_reg.sckPrev;
    assign lrEdge = active & (lrckNow != s_reg.lrckPrev);

    // Whole next state; events are set here and the status merge lets set win.
    always_comb begin
        s_next = s_reg;
        evSet = 3'h0;
        evClr = 3'h0;
        s_next.rxValid = 1'b0;
        s_next.txTake = 1'b0;
        s_next.sckPrev = sckNow;
        s_next.lrckPrev = lrckNow;
        if (wrEn) begin
            case (apbReq.paddr)
                OFS_START: begin
                    if (apbReq.pwdata[0] && s_reg.enable) begin
                        s_next.run = I2SC_RUN;
                        s_next.acc = 32'h00000000;
                        s_next.lrCnt = 10'h000;
                        s_next.sckCnt = 5'h00;
                        s_next.frame_select_clock = 1'b0;
                        s_next.sck = 1'b0;
                        s_next.rxCnt = {CNT_W{1'b0}};
                        s_next.txCnt = {CNT_W{1'b0}};
                        s_next.rxBase = s_reg.rxPtr;
                        // In master mode the fresh clocks start low; forget the old levels so no false edge follows.
                        if (!s_reg.mode) begin
                            s_next.sckPrev = 1'b0;
                            s_next.lrckPrev = 1'b0;
                        end
                    end
                end
                OFS_STOP: begin
                    if (apbReq.pwdata[0]) begin
                        s_next.run = I2SC_IDLE;
                        evSet[EV_STOP] = 1'b1;
                    end
                end
                OFS_STATUS: evClr = apbReq.pwdata[2:0];
                OFS_MASK: s_next.mask = apbReq.pwdata[2:0];
                OFS_ENABLE: s_next.enable = apbReq.pwdata[0];
                OFS_MODE: s_next.mode = apbReq.pwdata[0];
                OFS_RECEIVE_ENABLE_BIT: s_next.receive_enable_bit = apbReq.pwdata[0];
                OFS_TRANSMIT_ENABLE_BIT: s_next.transmit_enable_bit = apbReq.pwdata[0];
                OFS_MASTER_CLOCK_GEN_ON: s_next.master_clock_gen_on = apbReq.pwdata[0];
                OFS_MASTER_CLOCK_FRACTION: s_next.master_clock_fraction = apbReq.pwdata;
                OFS_RATIO: s_next.ratio = apbReq.pwdata[3:0];
                OFS_SAMPLE_BITS: s_next.sampleBits = apbReq.pwdata[1:0];
                OFS_RXPTR: s_next.rxPtr = apbReq.pwdata;
                OFS_MAXCNT: s_next.maxCnt = apbReq.pwdata[CNT_W-1:0];
                default: s_next.run = s_reg.run;
            endcase
        end
        // Disabling the module drops transfer at once.
        if (!s_reg.enable) begin
            s_next.run = I2SC_IDLE;
        end
        // Master clock and the clocks derived from it advance only while running.
        if (active) begin
            s_next.acc = accNext;
        end
        if (mckEdge) begin
            if (s_reg.lrCnt == lrEdges - 10'h001) begin
                s_next.lrCnt = 10'h000;
                s_next.frame_select_clock = ~s_reg.frame_select_clock;
            end else begin
                s_next.lrCnt = s_reg.lrCnt + 10'h001;
            end
            if (s_reg.sckCnt == sckHalf - 5'h01) begin
                s_next.sckCnt = 5'h00;
                s_next.sck = ~s_reg.sck;
            end else begin
                s_next.sckCnt = s_reg.sckCnt + 5'h01;
            end
        end
        // Receive shifts on the bit clock rise and closes a word at each frame edge.
        if (active && s_reg.receive_enable_bit && sckRise) begin
            s_next.rxShift = {s_reg.rxShift[WORD_BITS-2:0], sdinIn};
        end
        if (lrEdge && s_reg.receive_enable_bit) begin
            s_next.rxValid = 1'b1;
            s_next.rxWord = s_reg.rxShift;
            s_next.rxAddr = s_reg.rxBase + {16'h0000, s_reg.rxCnt, 2'b00};
            if (s_reg.rxCnt + 14'h0001 >= s_reg.maxCnt) begin
                s_next.rxCnt = {CNT_W{1'b0}};
                s_next.rxBase = s_reg.rxPtr;
                evSet[EV_RX] = 1'b1;
            end else begin
                s_next.rxCnt = s_reg.rxCnt + 14'h0001;
            end
        end
        // Transmit loads a word at each frame edge and shifts on the bit clock fall.
        if (lrEdge && s_reg.transmit_enable_bit) begin
            s_next.txShift = txWordData;
            s_next.txTake = 1'b1;
            if (s_reg.txCnt + 14'h0001 >= s_reg.maxCnt) begin
                s_next.txCnt = {CNT_W{1'b0}};
                evSet[EV_TX] = 1'b1;
            end else begin
                s_next.txCnt = s_reg.txCnt + 14'h0001;
            end
        end else if (active && s_reg.transmit_enable_bit && sckFall) begin
            s_next.txShift = {s_reg.txShift[WORD_BITS-2:0], 1'b0};
        end
        s_next.status = (s_reg.status & ~evClr) | evSet;
    end

    // Single state register with documented reset values.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_reg <= '0;
            s_reg.transmit_enable_bit <= RST_TRANSMIT_ENABLE_BIT;
            s_reg.master_clock_gen_on <= RST_MASTER_CLOCK_GEN_ON;
            s_reg.master_clock_fraction <= RST_MASTER_CLOCK_FRACTION;
            s_reg.ratio <= RST_RATIO;
            s_reg.sampleBits <= RST_SAMPLE_BITS;
        end else begin
            s_reg <= s_next;
        end
    end

    // Pins are owned by the block only while it is enabled; mck also needs master_clock_gen_on, sck and lrck need master mode.
    assign mckOe = s_reg.enable & s_reg.master_clock_gen_on;
    assign mckOut = active & s_reg.master_clock_gen_on & s_reg.acc[31];
    assign sckOe = s_reg.enable & ~s_reg.mode;
    assign lrckOe = s_reg.enable & ~s_reg.mode;
    assign sckOut = s_reg.sck;
    assign lrckOut = s_reg.frame_select_clock;
    assign sdoutOe = s_reg.enable;
    assign sdoutOut = s_reg.txShift[WORD_BITS-1];
    assign rxWordValid = s_reg.rxValid;
    assign rxWordAddr = s_reg.rxAddr;
    assign rxWordData = s_reg.rxWord;
    assign txWordTake = s_reg.txTake;
    // Level interrupt; it falls only once software clears or masks every source.
    assign irq = |(s_reg.status & s_reg.mask);

    // Properties on bus writes, clock generation and the receive path.
    sequence stopWrite;
        wrEn && apbReq.paddr == OFS_STOP && apbReq.pwdata[0];
    endsequence
    sequence stoppedSeen;
        s_reg.status[EV_STOP] && s_reg.run == I2SC_IDLE;
    endsequence

    a_stop_raises: assert property (@(posedge clk_sys) disable iff (sys_rst)
        stopWrite |=> stoppedSeen) else $error("stop did not halt and raise event");
    a_rx_gated: assert property (@(posedge clk_sys) disable iff (sys_rst)
        rxWordValid |-> $past(s_reg.receive_enable_bit)) else $error("word written with reception off");
    a_enable_bit: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wrEn && apbReq.paddr == OFS_ENABLE |=> s_reg.enable == $past(apbReq.pwdata[0]))
        else $error("enable bit not stored");
    a_receive_enable_bit_bit: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wrEn && apbReq.paddr == OFS_RECEIVE_ENABLE_BIT |=> s_reg.receive_enable_bit == $past(apbReq.pwdata[0]))
        else $error("receive enable not stored");
    a_fast_mck: assert property (@(posedge clk_sys) disable iff (sys_rst)
        active && s_reg.master_clock_gen_on && s_reg.master_clock_fraction == MASTER_CLOCK_FRACTION_DIV2 && $past(active)
        && $past(s_reg.master_clock_gen_on) && $past(s_reg.master_clock_fraction) == MASTER_CLOCK_FRACTION_DIV2
        |-> mckOut != $past(mckOut))
        else $error("fastest code does not halve the source");
    a_freq_reset: assert property (@(posedge clk_sys)
        sys_rst |=> s_reg.master_clock_fraction == RST_MASTER_CLOCK_FRACTION && s_reg.ratio == RST_RATIO)
        else $error("reset value of clock settings wrong");
    a_start_runs: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wrEn && apbReq.paddr == OFS_START && apbReq.pwdata[0] && s_reg.enable |=> active)
        else $error("start did not begin transfer");
    a_pin_owned: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_reg.enable && !s_reg.mode |-> sckOe && lrckOe && sdoutOe)
        else $error("master pins not driven while enabled");
    a_slave_clock: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_reg.mode |-> !sckOe && !lrckOe) else $error("slave mode drives clocks");
    a_rx_event: assert property (@(posedge clk_sys) disable iff (sys_rst)
        lrEdge && s_reg.receive_enable_bit && s_reg.rxCnt + 14'h0001 >= s_reg.maxCnt && !evClr[EV_RX]
        |=> s_reg.status[EV_RX] && s_reg.rxCnt == 14'h0000)
        else $error("receive pointer event missing");
    a_rx_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !s_reg.receive_enable_bit |=> !rxWordValid)
        else $error("receive word produced while reception off");
    a_stop_clock: assert property (@(posedge clk_sys) disable iff (sys_rst)
        stopWrite |=> !mckOut)
        else $error("master clock still running after stop");
endmodule

// >>> i2sc_pkg.sv
package i2sc_pkg;
    localparam logic [11:0] OFS_START = 12'h000;
    localparam logic [11:0] OFS_STOP = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h10C;
    localparam logic [11:0] OFS_MASK = 12'h300;
    localparam logic [11:0] OFS_ENABLE = 12'h500;
    localparam logic [11:0] OFS_MODE = 12'h504;
    localparam logic [11:0] OFS_RECEIVE_ENABLE_BIT = 12'h508;
    localparam logic [11:0] OFS_TRANSMIT_ENABLE_BIT = 12'h50C;
    localparam logic [11:0] OFS_MASTER_CLOCK_GEN_ON = 12'h510;
    localparam logic [11:0] OFS_MASTER_CLOCK_FRACTION = 12'h514;
    localparam logic [11:0] OFS_RATIO = 12'h518;
    localparam logic [11:0] OFS_SAMPLE_BITS = 12'h51C;
    localparam logic [11:0] OFS_RXPTR = 12'h538;
    localparam logic [11:0] OFS_MAXCNT = 12'h550;
    localparam logic RST_TRANSMIT_ENABLE_BIT = 1'h1;
    localparam logic RST_MASTER_CLOCK_GEN_ON = 1'h1;
    localparam logic [31:0] RST_MASTER_CLOCK_FRACTION = 32'h20000000;
    localparam logic [31:0] MASTER_CLOCK_FRACTION_DIV2 = 32'h80000000;
    localparam logic [3:0] RST_RATIO = 4'h6;
    localparam logic [1:0] RST_SAMPLE_BITS = 2'h1;
    localparam int EV_RX = 0;
    localparam int EV_STOP = 1;
    localparam int EV_TX = 2;
    localparam int WORD_BITS = 16;
    localparam int CNT_W = 14;
    typedef enum logic {I2SC_IDLE = 1'b0, I2SC_RUN = 1'b1} i2sc_run_t;
    typedef struct packed {
        logic enable;
        logic mode;
        logic receive_enable_bit;
        logic transmit_enable_bit;
        logic master_clock_gen_on;
        logic [31:0] master_clock_fraction;
        logic [3:0] ratio;
        logic [1:0] sampleBits;
        logic [31:0] rxPtr;
        logic [CNT_W-1:0] maxCnt;
        logic [2:0] status;
        logic [2:0] mask;
        i2sc_run_t run;
        logic [31:0] acc;
        logic frame_select_clock;
        logic sck;
        logic [9:0] lrCnt;
        logic [4:0] sckCnt;
        logic sckPrev;
        logic lrckPrev;
        logic [WORD_BITS-1:0] rxShift;
        logic [WORD_BITS-1:0] rxWord;
        logic rxValid;
        logic [31:0] rxAddr;
        logic [31:0] rxBase;
        logic [CNT_W-1:0] rxCnt;
        logic [WORD_BITS-1:0] txShift;
        logic [CNT_W-1:0] txCnt;
        logic txTake;
    } i2sc_state_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } i2sc_apb_req_t;
endpackage

// >>> testbench.sv
`timescale 1ns/100ps
module testbench
    import i2sc_pkg::*;
;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    i2sc_apb_req_t apbReq = '0;
    logic [31:0] prdata, rxWordAddr, rdv, base, nxtPtr, ptr;
    logic pready, pslverr, irq, mckOut, mckOe, sckIn, sckOut, sckOe, lrckIn, lrckOut, lrckOe;
    logic sdinIn, sdoutOut, sdoutOe, rxWordValid, txWordTake, err, skipData;
    logic rxOn = 1'b0;
    logic lrPrev = 1'b0;
    logic [15:0] rxWordData, txWordData, word;
    logic [48:0] expQ[$];
    logic [48:0] e;
    int n_errors = 0;
    int compares = 0;
    int k, cnt, nSck;
    logic [11:0] ofs[8] = '{OFS_ENABLE, OFS_MODE, OFS_RECEIVE_ENABLE_BIT, OFS_TRANSMIT_ENABLE_BIT, OFS_MASTER_CLOCK_GEN_ON, OFS_MASTER_CLOCK_FRACTION, OFS_RATIO, OFS_SAMPLE_BITS};
    logic [31:0] rstv[8] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h1, 32'h20000000, 32'h6, 32'h1};
    logic [31:0] fcode[4] = '{32'h80000000, 32'h50000000, 32'h20000000, 32'h020C0000};
    int fdiv[4] = '{2, 3, 8, 125};
    int rat[9] = '{32, 48, 64, 96, 128, 192, 256, 384, 512};

    i2sc_core DUT (.clk_sys, .sys_rst, .apbReq, .prdata, .pready, .pslverr, .irq, .mckOut, .mckOe, .sckIn,
        .sckOut, .sckOe, .lrckIn, .lrckOut, .lrckOe, .sdinIn, .sdoutOut, .sdoutOe, .rxWordValid, .rxWordAddr,
        .rxWordData, .txWordData, .txWordTake);
    i2sc_codec_model codec (.clk_sys, .sck(sckIn), .frame_select_clock(lrckIn), .serial_data_in(sdinIn));

    always #25 clk_sys = ~clk_sys;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One bus transfer; the request is held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin
            n_errors++;
            summarize();
        end
        rdv = prdata;
        err = pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic countMck(input int n);
        logic p;
        p = mckOut;
        cnt = 0;
        repeat (n) begin
            @(posedge clk_sys);
            if (mckOut === 1'b1 && p !== 1'b1) cnt++;
            p = mckOut;
        end
    endtask

    // Counts cycles and bit clock flips over one half of the frame clock.
    task automatic lrHalf();
        logic l, s;
        l = lrckOut;
        s = sckOut;
        cnt = 0;
        nSck = 0;
        while (lrckOut === l && cnt < 2000) begin
            @(posedge clk_sys);
            cnt++;
            if (sckOut !== s) nSck++;
            s = sckOut;
        end
        if (cnt >= 2000) begin
            n_errors++;
            summarize();
        end
    endtask

    // Each frame edge sent while reception is on notes the expected address and word.
    always @(posedge clk_sys) begin
        lrPrev <= lrckIn;
        if (rxOn && lrckIn !== lrPrev) begin
            expQ.push_back({!skipData, base + 32'(4 * k), word});
            skipData = 1'b0;
            k++;
            if (k == 4) begin
                k = 0;
                base = nxtPtr;
            end
        end
    end

    // Each received word takes the oldest note; a word with no note pending is a fault.
    always @(posedge clk_sys) begin
        if (rxWordValid === 1'b1) begin
            if (expQ.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                e = expQ.pop_front();
                chk(rxWordAddr, e[47:16]);
                if (e[48]) chk({16'h0, rxWordData}, {16'h0, e[15:0]});
            end
        end
        if (txWordTake === 1'b1) chk({31'h0, sdoutOut}, {31'h0, txWordData[15]});
    end

    // A hang anywhere ends the run through the same closing report.
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_errors++;
        summarize();
    end

    initial begin
        void'($urandom(48));
        txWordData = 16'($urandom());
        word = 16'($urandom());
        ptr = $urandom() & 32'hFFFFFFFC;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, ofs[i], 32'h0);
            chk(rdv, rstv[i]);
        end
        apb(1'b0, 12'h7FC, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rdv, 32'h0);
        chk({28'h0, mckOe, sckOe, lrckOe, sdoutOe}, 32'h0);
        $display("Register test done");
        apb(1'b1, OFS_ENABLE, 32'h1);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFS_MASTER_CLOCK_FRACTION, fcode[i]);
            apb(1'b1, OFS_START, 32'h1);
            countMck(100 * fdiv[i]);
            chk({31'h0, cnt >= 99 && cnt <= 101}, 32'h1);
            apb(1'b1, OFS_STOP, 32'h1);
        end
        countMck(50);
        chk(cnt, 32'h0);
        chk({28'h0, mckOe, sckOe, lrckOe, sdoutOe}, 32'hF);
        apb(1'b1, OFS_MASTER_CLOCK_GEN_ON, 32'h0);
        apb(1'b1, OFS_START, 32'h1);
        countMck(100);
        chk(cnt, 32'h0);
        apb(1'b1, OFS_STOP, 32'h1);
        apb(1'b1, OFS_MASTER_CLOCK_GEN_ON, 32'h1);
        $display("Master clock test done");
        apb(1'b1, OFS_MASTER_CLOCK_FRACTION, 32'h80000000);
        for (int r = 0; r < 9; r++) begin
            apb(1'b1, OFS_RATIO, 32'(r));
            apb(1'b1, OFS_START, 32'h1);
            repeat (3) lrHalf();
            chk(cnt, rat[r]);
            chk(nSck, rat[r] / (rat[r] < 64 ? 1 : rat[r] / 32));
            apb(1'b1, OFS_STOP, 32'h1);
        end
        $display("Ratio test done");
        apb(1'b1, OFS_STATUS, 32'h7);
        apb(1'b1, OFS_MODE, 32'h1);
        apb(1'b1, OFS_MAXCNT, 32'h4);
        apb(1'b1, OFS_RXPTR, ptr);
        apb(1'b1, OFS_MASK, 32'h2);
        apb(1'b1, OFS_START, 32'h1);
        chk({30'h0, sckOe, lrckOe}, 32'h0);
        codec.send(3, word);
        apb(1'b1, OFS_STOP, 32'h1);
        @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, OFS_MASK, 32'h0);
        @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rdv & 32'h2, 32'h2);
        apb(1'b1, OFS_STATUS, 32'h7);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rdv & 32'h2, 32'h0);
        $display("Receive-off and interrupt test done");
        apb(1'b1, OFS_RECEIVE_ENABLE_BIT, 32'h1);
        apb(1'b1, OFS_START, 32'h1);
        base = ptr;
        nxtPtr = ptr;
        k = 0;
        skipData = 1'b1;
        rxOn = 1'b1;
        fork
            codec.send(9, word);
            begin
                repeat (100) @(posedge clk_sys);
                nxtPtr = ptr ^ 32'h100;
                apb(1'b1, OFS_RXPTR, nxtPtr);
            end
        join
        repeat (4) @(posedge clk_sys);
        chk(expQ.size(), 32'h0);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rdv & 32'h1, 32'h1);
        apb(1'b1, OFS_STOP, 32'h1);
        rxOn = 1'b0;
        $display("Receive test done");
        summarize();
    end
endmodule
